// >>> src/dpc_pkg.sv
// Package of constants for the digital I/O port configuration block
// Operation
// - Thirty-two data lines form four eight-line ports, each direction set by software.
// - Port A lines 0-7, B 8-15, C 16-23, D 24-31.
// - After reset every data line is an input; no port drives.
// - A port switched to output starts tri-stated.
// - Acquisition width 8/16/24/32 bits; samples packed into 32-bit words.
// - Function pins 0-5 take serial, handshake, trigger or event roles.
// - Function pin 6 also carries output-side sample clock in or out.
// - Function pin 7 also carries input-side sample clock in or out.
// - Clock input jack, when selected, feeds external clock to both sample clocks together.
// - Clock output jack exports the selected sample clock.
// - Activity indicator red on input DMA, green output, amber both.
// - One logic-level setting of three applies to all pins.
package dpc_pkg;
  localparam int DPC_PORTS = 4;
  localparam int DPC_PORT_W = 8;
  localparam int DPC_FPINS = 8;
  // Register byte offsets
  localparam logic [7:0] DPC_DIR_OFF = 8'h00;
  localparam logic [7:0] DPC_DRV_OFF = 8'h04;
  localparam logic [7:0] DPC_DOUT_OFF = 8'h08;
  localparam logic [7:0] DPC_DIN_OFF = 8'h0C;
  localparam logic [7:0] DPC_WIDTH_OFF = 8'h10;
  localparam logic [7:0] DPC_FUNC_OFF = 8'h14;
  localparam logic [7:0] DPC_CLK_OFF = 8'h18;
  localparam logic [7:0] DPC_LVL_OFF = 8'h1C;
  localparam logic [7:0] DPC_DMA_OFF = 8'h20;
  localparam logic [7:0] DPC_PACK_OFF = 8'h24;
  localparam logic [7:0] DPC_STAT_OFF = 8'h28;
  // Reset values
  localparam logic [3:0] DPC_DIR_RST = 4'h0;
  localparam logic [1:0] DPC_LVL_RST = 2'h2;
  // Function pin roles, 3 bits per pin
  localparam logic [2:0] DPC_ROLE_GPIN = 3'h0;
  localparam logic [2:0] DPC_ROLE_SERIAL = 3'h1;
  localparam logic [2:0] DPC_ROLE_HSHAKE = 3'h2;
  localparam logic [2:0] DPC_ROLE_TRIG_IN = 3'h3;
  localparam logic [2:0] DPC_ROLE_TRIG_OUT = 3'h4;
  localparam logic [2:0] DPC_ROLE_EVENT = 3'h5;
  localparam logic [2:0] DPC_ROLE_CLK_IN = 3'h6;
  localparam logic [2:0] DPC_ROLE_CLK_OUT = 3'h7;
  // Clock register fields
  localparam int DPC_CLK_IN_SRC = 0;
  localparam int DPC_CLK_OUT_SRC = 1;
  localparam int DPC_CLK_OUT_EN = 2;
  localparam int DPC_CLK_DIV_LSB = 8;
  localparam logic [15:0] DPC_DIV_RST = 16'h0001;
  // Level encodings
  localparam logic [1:0] DPC_LVL_1V8 = 2'h0;
  localparam logic [1:0] DPC_LVL_2V5 = 2'h1;
  localparam logic [1:0] DPC_LVL_3V3 = 2'h2;
  // Activity colours
  localparam logic [1:0] DPC_LED_OFF = 2'h0;
  localparam logic [1:0] DPC_LED_RED = 2'h1;
  localparam logic [1:0] DPC_LED_GREEN = 2'h2;
  localparam logic [1:0] DPC_LED_AMBER = 2'h3;
endpackage

// >>> src/dpc_packer.sv
// Sample packer folding narrow acquisition samples into 32-bit words
`timescale 1ns/10ps
`default_nettype none
module dpc_packer (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clr,
  input wire logic smp_valid,
  input wire logic [1:0] width_sel,
  input wire logic [31:0] smp,
  output logic word_valid,
  output logic [31:0] word
);
  import dpc_pkg::*;
  typedef struct packed {
    logic [31:0] acc;
    logic [1:0] fill;
    logic [31:0] word;
    logic valid;
  } dpc_pk_s;
  dpc_pk_s st_reg;
  dpc_pk_s st_next;

  // Lanes fill from the low byte upward; width_sel 0..3 means 1..4 bytes
  always_comb begin
    logic [31:0] sh;
    logic [2:0] nfill;
    sh = 32'h0000_0000;
    nfill = 3'h0;
    st_next = st_reg;
    st_next.valid = 1'b0;
    if (clr) begin
      st_next.fill = 2'h0;
      st_next.acc = 32'h0000_0000;
    end else if (smp_valid) begin
      case (width_sel)
        2'h0: sh = {24'h000000, smp[7:0]} << {st_reg.fill, 3'h0};
        2'h1: sh = {16'h0000, smp[15:0]} << {st_reg.fill, 3'h0};
        2'h2: sh = {8'h00, smp[23:0]} << {st_reg.fill, 3'h0};
        default: sh = smp;
      endcase
      nfill = {1'b0, st_reg.fill} + {1'b0, width_sel} + 3'h1;
      if (nfill >= 3'h4) begin
        st_next.word = st_reg.acc | sh;
        st_next.valid = 1'b1;
        st_next.acc = 32'h0000_0000;
        st_next.fill = 2'h0;
        // 24-bit spills: carry the remainder into the next word
        if (nfill > 3'h4) begin
          st_next.acc = {8'h00, smp[23:0]} >> {(3'h4 - {1'b0, st_reg.fill}), 3'h0};
          st_next.fill = nfill[1:0];
        end
      end else begin
        st_next.acc = st_reg.acc | sh;
        st_next.fill = nfill[1:0];
      end
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign word_valid = st_reg.valid;
  assign word = st_reg.word;
endmodule
`default_nettype wire

// >>> src/dpc_top.sv
// Digital I/O port configuration, function pins and APB registers
//
// The register addresses and the APB register port are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module dpc_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [31:0] data_in,
  output logic [31:0] data_out,
  output logic [31:0] data_oe_n,
  input wire logic [dpc_pkg::DPC_FPINS-1:0] app_function_pin_in,
  output logic [dpc_pkg::DPC_FPINS-1:0] app_function_pin_out,
  output logic [dpc_pkg::DPC_FPINS-1:0] app_function_pin_oe_n,
  input wire logic [dpc_pkg::DPC_FPINS-1:0] role_sig_out,
  output logic [dpc_pkg::DPC_FPINS-1:0] role_sig_in,
  input wire logic in_sample_clk_int,
  input wire logic out_sample_clk_int,
  output logic in_sample_clk_sel,
  output logic out_sample_clk_sel,
  input wire logic clk_in_jack,
  output logic clk_out_jack,
  output logic [1:0] logic_level,
  output logic [1:0] activity_indicator,
  input wire logic pattern_acquire_strobe,
  output logic pack_word_valid
);
  import dpc_pkg::*;

  typedef struct packed {
    logic [3:0] dir;
    logic [3:0] drv;
    logic [31:0] dout;
    logic [31:0] din;
    logic [1:0] width;
    logic [23:0] func;
    logic [2:0] clkc;
    logic [1:0] lvl;
    logic [1:0] dma;
    logic [31:0] pack;
    logic [31:0] oe_n;
    logic [7:0] fpo;
    logic [7:0] fpoe_n;
    logic [7:0] fpi;
    logic insel;
    logic outsel;
    logic cko;
    logic [1:0] led;
    logic [31:0] rdata;
    logic ready;
    logic err;
  } dpc_st_s;

  dpc_st_s st_reg;
  dpc_st_s st_next;
  logic pk_valid;
  logic [31:0] pk_word;
  logic acc_phase;
  logic wr_en;
  logic hit;

  // Acquired samples folded into transfer words
  dpc_packer u_packer (
    .pclk(pclk),
    .presetn(presetn),
    .clr(wr_en && paddr == DPC_WIDTH_OFF),
    .smp_valid(pattern_acquire_strobe),
    .width_sel(st_reg.width),
    .smp(st_reg.din),
    .word_valid(pk_valid),
    .word(pk_word)
  );

  // APB decode; answer one cycle after the access edge, writes land on the completing edge
  assign acc_phase = psel && penable && !st_reg.ready;
  assign wr_en = psel && penable && pwrite && st_reg.ready;
  always_comb begin
    case (paddr)
      DPC_DIR_OFF, DPC_DRV_OFF, DPC_DOUT_OFF, DPC_DIN_OFF, DPC_WIDTH_OFF, DPC_FUNC_OFF,
      DPC_CLK_OFF, DPC_LVL_OFF, DPC_DMA_OFF, DPC_PACK_OFF, DPC_STAT_OFF: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end

  // Next-state logic for all registers and pin drivers
  always_comb begin
    logic [2:0] role;
    logic ck;
    role = 3'h0;
    ck = 1'b0;
    st_next = st_reg;
    st_next.ready = acc_phase;
    st_next.err = acc_phase && !hit;
    st_next.din = data_in;
    if (pk_valid) begin
      st_next.pack = pk_word;
    end
    // Register writes
    if (wr_en) begin
      case (paddr)
        DPC_DIR_OFF: begin
          st_next.dir = pwdata[3:0];
          // Newly turned outputs lose their drive enable
          st_next.drv = st_reg.drv & ~(pwdata[3:0] & ~st_reg.dir);
        end
        DPC_DRV_OFF: st_next.drv = pwdata[3:0];
        DPC_DOUT_OFF: st_next.dout = pwdata;
        DPC_WIDTH_OFF: st_next.width = pwdata[1:0];
        DPC_FUNC_OFF: st_next.func = pwdata[23:0];
        DPC_CLK_OFF: st_next.clkc = pwdata[2:0];
        DPC_LVL_OFF: st_next.lvl = (pwdata[1:0] == 2'h3) ? st_reg.lvl : pwdata[1:0];
        DPC_DMA_OFF: st_next.dma = pwdata[1:0];
        default: ;
      endcase
    end
    // Register reads
    st_next.rdata = 32'h0000_0000;
    if (acc_phase && !pwrite) begin
      case (paddr)
        DPC_DIR_OFF: st_next.rdata = {28'h0000000, st_reg.dir};
        DPC_DRV_OFF: st_next.rdata = {28'h0000000, st_reg.drv};
        DPC_DOUT_OFF: st_next.rdata = st_reg.dout;
        DPC_DIN_OFF: st_next.rdata = st_reg.din;
        DPC_WIDTH_OFF: st_next.rdata = {30'h00000000, st_reg.width};
        DPC_FUNC_OFF: st_next.rdata = {8'h00, st_reg.func};
        DPC_CLK_OFF: st_next.rdata = {29'h00000000, st_reg.clkc};
        DPC_LVL_OFF: st_next.rdata = {30'h00000000, st_reg.lvl};
        DPC_DMA_OFF: st_next.rdata = {30'h00000000, st_reg.dma};
        DPC_PACK_OFF: st_next.rdata = st_reg.pack;
        DPC_STAT_OFF: st_next.rdata = {14'h0000, st_reg.fpi, ~st_reg.oe_n[31:24], 2'h0};
        default: st_next.rdata = 32'h0000_0000;
      endcase
    end
    // Port drivers: port p owns lines 8p..8p+7
    for (int p = 0; p < DPC_PORTS; p++) begin
      st_next.oe_n[p*DPC_PORT_W +: DPC_PORT_W] = {DPC_PORT_W{~(st_next.dir[p] & st_next.drv[p])}};
    end
    // Sample clock selection from jack or dedicated function pins
    st_next.insel = st_reg.clkc[DPC_CLK_IN_SRC] ? clk_in_jack :
      ((st_reg.func[21 +: 3] == DPC_ROLE_CLK_IN) ? app_function_pin_in[7] : in_sample_clk_int);
    st_next.outsel = st_reg.clkc[DPC_CLK_IN_SRC] ? clk_in_jack :
      ((st_reg.func[18 +: 3] == DPC_ROLE_CLK_IN) ? app_function_pin_in[6] : out_sample_clk_int);
    ck = st_reg.clkc[DPC_CLK_OUT_SRC] ? st_reg.outsel : st_reg.insel;
    st_next.cko = st_reg.clkc[DPC_CLK_OUT_EN] & ck;
    // Function pin roles
    st_next.fpi = app_function_pin_in;
    for (int i = 0; i < DPC_FPINS; i++) begin
      role = st_reg.func[i*3 +: 3];
      st_next.fpo[i] = role_sig_out[i];
      st_next.fpoe_n[i] = 1'b1;
      case (role)
        DPC_ROLE_SERIAL, DPC_ROLE_HSHAKE, DPC_ROLE_TRIG_OUT, DPC_ROLE_EVENT: begin
          st_next.fpoe_n[i] = (role == DPC_ROLE_SERIAL && i > 5) ? 1'b1 : 1'b0;
        end
        DPC_ROLE_CLK_OUT: begin
          if (i == 6) begin
            st_next.fpo[i] = st_reg.outsel;
            st_next.fpoe_n[i] = 1'b0;
          end else if (i == 7) begin
            st_next.fpo[i] = st_reg.insel;
            st_next.fpoe_n[i] = 1'b0;
          end
        end
        default: ;
      endcase
    end
    // Activity colour from running DMA directions
    case (st_reg.dma)
      2'h1: st_next.led = DPC_LED_RED;
      2'h2: st_next.led = DPC_LED_GREEN;
      2'h3: st_next.led = DPC_LED_AMBER;
      default: st_next.led = DPC_LED_OFF;
    endcase
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
      st_reg.dir <= DPC_DIR_RST;
      st_reg.lvl <= DPC_LVL_RST;
      st_reg.oe_n <= 32'hFFFF_FFFF;
      st_reg.fpoe_n <= 8'hFF;
    end else begin
      st_reg <= st_next;
    end
  end

  assign prdata = st_reg.rdata;
  assign pready = st_reg.ready;
  assign pslverr = st_reg.err;
  assign data_out = st_reg.dout;
  assign data_oe_n = st_reg.oe_n;
  assign app_function_pin_out = st_reg.fpo;
  assign app_function_pin_oe_n = st_reg.fpoe_n;
  assign role_sig_in = st_reg.fpi;
  assign in_sample_clk_sel = st_reg.insel;
  assign out_sample_clk_sel = st_reg.outsel;
  assign clk_out_jack = st_reg.cko;
  assign logic_level = st_reg.lvl;
  assign activity_indicator = st_reg.led;
  assign pack_word_valid = pk_valid;

  // Checks: port drive enables
  drive_needs_out_a: assert property (@(posedge pclk) disable iff (!presetn)
    !data_oe_n[0] |-> st_reg.dir[0] && st_reg.drv[0]) else $error("port driven without enable");
  port_b_drive_a: assert property (@(posedge pclk) disable iff (!presetn)
    !data_oe_n[8] |-> st_reg.dir[1] && st_reg.drv[1]) else $error("port B driven without enable");
  port_c_drive_a: assert property (@(posedge pclk) disable iff (!presetn)
    !data_oe_n[16] |-> st_reg.dir[2] && st_reg.drv[2]) else $error("port C driven without enable");
  port_d_drive_a: assert property (@(posedge pclk) disable iff (!presetn)
    !data_oe_n[24] |-> st_reg.dir[3] && st_reg.drv[3]) else $error("port D driven without enable");
  port_a_on_a: assert property (@(posedge pclk) disable iff (!presetn)
    st_reg.dir[0] && st_reg.drv[0] |-> !data_oe_n[0]) else $error("port A enabled but released");
  port_c_on_a: assert property (@(posedge pclk) disable iff (!presetn)
    st_reg.dir[2] && st_reg.drv[2] |-> !data_oe_n[16]) else $error("port C enabled but released");
  drv_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && paddr == DPC_DRV_OFF |=> st_reg.drv == $past(pwdata[3:0])) else $error("drive enable lost");

  // Checks: direction changes start tri-stated
  turn_out_tri_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && paddr == DPC_DIR_OFF && pwdata[0] && !st_reg.dir[0] |=> data_oe_n[7:0] == 8'hFF)
    else $error("new output port not tri-stated");
  turn_out_c_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && paddr == DPC_DIR_OFF && pwdata[2] && !st_reg.dir[2] |=> data_oe_n[23:16] == 8'hFF)
    else $error("new output port C not tri-stated");
  drv_cleared_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && paddr == DPC_DIR_OFF && pwdata[0] && !st_reg.dir[0] |=> !st_reg.drv[0])
    else $error("drive enable kept on direction change");
  dir_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && paddr == DPC_DIR_OFF |=> st_reg.dir == $past(pwdata[3:0])) else $error("direction lost");

  // Checks: lines move as whole ports
  port_a_group_a: assert property (@(posedge pclk) disable iff (!presetn)
    data_oe_n[7:0] == {8{data_oe_n[0]}}) else $error("port A lines split");
  port_b_group_a: assert property (@(posedge pclk) disable iff (!presetn)
    data_oe_n[15:8] == {8{data_oe_n[8]}}) else $error("port B lines split");
  port_group_a: assert property (@(posedge pclk) disable iff (!presetn)
    data_oe_n[23:16] == {8{data_oe_n[16]}}) else $error("port lines split");
  port_d_group_a: assert property (@(posedge pclk) disable iff (!presetn)
    data_oe_n[31:24] == {8{data_oe_n[24]}}) else $error("port D lines split");

  // Checks: state seen at the first edge after reset
  reset_input_a: assert property (@(posedge pclk) $rose(presetn) |-> data_oe_n == 32'hFFFF_FFFF)
    else $error("lines driven after reset");
  reset_fpin_a: assert property (@(posedge pclk) $rose(presetn) |-> app_function_pin_oe_n == 8'hFF)
    else $error("function pins driven after reset");
  reset_dir_a: assert property (@(posedge pclk) $rose(presetn) |-> st_reg.dir == DPC_DIR_RST)
    else $error("ports not inputs after reset");
  reset_level_a: assert property (@(posedge pclk) $rose(presetn) |-> logic_level == DPC_LVL_RST)
    else $error("level wrong after reset");
  reset_led_a: assert property (@(posedge pclk) $rose(presetn) |-> activity_indicator == DPC_LED_OFF)
    else $error("indicator lit after reset");
  reset_clk_a: assert property (@(posedge pclk) $rose(presetn) |-> !clk_out_jack)
    else $error("clock exported after reset");

  // Checks: acquisition packing
  width_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && paddr == DPC_WIDTH_OFF |=> st_reg.width == $past(pwdata[1:0])) else $error("width lost");
  pack_word_a: assert property (@(posedge pclk) disable iff (!presetn)
    st_reg.width == 2'h3 && pattern_acquire_strobe && !(wr_en && paddr == DPC_WIDTH_OFF) |=> pack_word_valid)
    else $error("no 32-bit word");

  // Checks: function pin roles
  event_drive_a: assert property (@(posedge pclk) disable iff (!presetn)
    st_reg.func[2:0] == DPC_ROLE_EVENT |=> !app_function_pin_oe_n[0]) else $error("event pin not driven");
  event_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
    st_reg.func[2:0] == DPC_ROLE_EVENT |=> app_function_pin_out[0] == $past(role_sig_out[0]))
    else $error("event pin value wrong");
  trig_in_release_a: assert property (@(posedge pclk) disable iff (!presetn)
    st_reg.func[5:3] == DPC_ROLE_TRIG_IN |=> app_function_pin_oe_n[1]) else $error("trigger input driven");
  pin_hi_serial_a: assert property (@(posedge pclk) disable iff (!presetn)
    st_reg.func[23:21] == DPC_ROLE_SERIAL |=> app_function_pin_oe_n[7]) else $error("pin 7 serial");
  pin6_clk_in_a: assert property (@(posedge pclk) disable iff (!presetn)
    st_reg.func[20:18] == DPC_ROLE_CLK_IN |=> app_function_pin_oe_n[6]) else $error("clock input pin driven");
  pin7_clk_out_a: assert property (@(posedge pclk) disable iff (!presetn)
    st_reg.func[23:21] == DPC_ROLE_CLK_OUT |=> !app_function_pin_oe_n[7] &&
    app_function_pin_out[7] == $past(in_sample_clk_sel)) else $error("input clock not exported on pin 7");

  // Checks: clock jacks
  jack_in_sel_a: assert property (@(posedge pclk) disable iff (!presetn)
    st_reg.clkc[DPC_CLK_IN_SRC] |=> in_sample_clk_sel == $past(clk_in_jack)) else $error("jack not input clock");
  jack_out_sel_a: assert property (@(posedge pclk) disable iff (!presetn)
    st_reg.clkc[DPC_CLK_IN_SRC] |=> out_sample_clk_sel == $past(clk_in_jack)) else $error("jack not output clock");
  clk_export_a: assert property (@(posedge pclk) disable iff (!presetn)
    !st_reg.clkc[DPC_CLK_OUT_EN] |=> !clk_out_jack) else $error("clock exported while off");
  export_in_a: assert property (@(posedge pclk) disable iff (!presetn)
    st_reg.clkc[DPC_CLK_OUT_EN] && !st_reg.clkc[DPC_CLK_OUT_SRC] |=> clk_out_jack == $past(in_sample_clk_sel))
    else $error("input clock not exported");
  export_out_a: assert property (@(posedge pclk) disable iff (!presetn)
    st_reg.clkc[DPC_CLK_OUT_EN] && st_reg.clkc[DPC_CLK_OUT_SRC] |=> clk_out_jack == $past(out_sample_clk_sel))
    else $error("output clock not exported");

  // Checks: activity colour
  led_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    st_reg.dma == 2'h0 |=> activity_indicator == DPC_LED_OFF) else $error("indicator lit when idle");
  led_red_a: assert property (@(posedge pclk) disable iff (!presetn)
    st_reg.dma == 2'h1 |=> activity_indicator == DPC_LED_RED) else $error("input colour wrong");
  led_green_a: assert property (@(posedge pclk) disable iff (!presetn)
    st_reg.dma == 2'h2 |=> activity_indicator == DPC_LED_GREEN) else $error("output colour wrong");
  led_amber_a: assert property (@(posedge pclk) disable iff (!presetn)
    st_reg.dma == 2'h3 |=> activity_indicator == DPC_LED_AMBER) else $error("activity colour wrong");

  // Checks: logic level setting
  level_legal_a: assert property (@(posedge pclk) disable iff (!presetn)
    logic_level != 2'h3) else $error("illegal logic level");
  level_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && paddr == DPC_LVL_OFF && pwdata[1:0] != 2'h3 |=> logic_level == $past(pwdata[1:0]))
    else $error("level write lost");
  level_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && paddr == DPC_LVL_OFF && pwdata[1:0] == 2'h3 |=> $stable(logic_level))
    else $error("illegal level accepted");
endmodule
`default_nettype wire

// >>> sim/dpc_dut_model.sv
// Far-side device model for the parallel lines and the clock jack
`timescale 1ns/10ps
`default_nettype none
module dpc_dut_model (
  input wire logic [31:0] data_out,
  input wire logic [31:0] data_oe_n,
  input wire logic [31:0] pattern,
  input wire logic jack_level,
  output logic [31:0] data_in,
  output logic clk_in_jack
);
  // Released lines carry the device pattern, driven lines the block value
  assign data_in = (data_out & ~data_oe_n) | (pattern & data_oe_n);
  // External clock supplied on the jack
  assign clk_in_jack = jack_level;
endmodule
`default_nettype wire

// >>> sim/testbench.sv
// Self-checking bench for the port configuration block
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_fail++; $display("[ERR] %s exp %h got %h", nm, e, g); end end
module testbench;
  import dpc_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 0, fp_in = 0, fp_out, fp_oe_n, rso = 0, rsi;
  logic [31:0] pwdata = 0, prdata, dout, oe_n, din, pat = 0, rd;
  logic pready, pslverr, err, isc = 0, osc = 0, in_sel, out_sel, jack, jlvl = 0, cko, stb = 0, pwv, seen;
  logic [1:0] lvl, led;
  logic [1:0] exp_led [4] = '{DPC_LED_OFF, DPC_LED_RED, DPC_LED_GREEN, DPC_LED_AMBER};
  int n_fail = 0, n_compared = 0, cyc = 0;
  dpc_top dpc_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .data_in(din), .data_out(dout), .data_oe_n(oe_n), .app_function_pin_in(fp_in),
    .app_function_pin_out(fp_out), .app_function_pin_oe_n(fp_oe_n), .role_sig_out(rso),
    .role_sig_in(rsi), .in_sample_clk_int(isc), .out_sample_clk_int(osc), .in_sample_clk_sel(in_sel),
    .out_sample_clk_sel(out_sel), .clk_in_jack(jack), .clk_out_jack(cko), .logic_level(lvl),
    .activity_indicator(led), .pattern_acquire_strobe(stb), .pack_word_valid(pwv));
  dpc_dut_model dpc_dut_model_i (.data_out(dout), .data_oe_n(oe_n), .pattern(pat), .jack_level(jlvl),
    .data_in(din), .clk_in_jack(jack));
  // Clock and watchdog
  initial begin
    forever #4 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    if (pwv === 1'b1) seen = 1;
    if (cyc == 20000) begin
      n_fail++;
      summarize();
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // One APB transfer, held until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic acq(input logic [31:0] v);
    pat <= v;
    tick(3);
    stb <= 1;
    tick(1);
    stb <= 0;
  endtask
  task automatic t_reset;
    `CHK("oe_n", 32'hFFFFFFFF, oe_n)
    `CHK("fp_oe_n", 8'hFF, fp_oe_n)
    `CHK("level", DPC_LVL_3V3, lvl)
    `CHK("led", DPC_LED_OFF, led)
    apb(0, DPC_DIR_OFF, 0);
    `CHK("dir", 32'h0, rd)
    $display("reset test done");
  endtask
  task automatic t_ports;
    apb(1, DPC_DIR_OFF, 32'h5);
    tick(2);
    `CHK("oe_n dir only", 32'hFFFFFFFF, oe_n)
    apb(1, DPC_DRV_OFF, 32'h5);
    apb(1, DPC_DOUT_OFF, 32'hCAFEF00D);
    tick(2);
    `CHK("oe_n A C", 32'hFF00FF00, oe_n)
    pat <= 32'h12345678;
    tick(3);
    apb(0, DPC_DIN_OFF, 0);
    `CHK("din mix", 32'h12FE560D, rd)
    apb(1, DPC_DIR_OFF, 32'h0);
    tick(2);
    `CHK("oe_n inputs", 32'hFFFFFFFF, oe_n)
    apb(1, DPC_DIR_OFF, 32'h5);
    tick(2);
    `CHK("oe_n redir", 32'hFFFFFFFF, oe_n)
    apb(1, DPC_DIR_OFF, 32'h0);
    $display("port test done");
  endtask
  task automatic t_pack;
    apb(1, DPC_WIDTH_OFF, 32'h1);
    seen = 0;
    acq(32'h0000BEEF);
    acq(32'h0000C0DE);
    tick(4);
    `CHK("word valid", 1'b1, seen)
    apb(0, DPC_PACK_OFF, 0);
    `CHK("pack 16", 32'hC0DEBEEF, rd)
    apb(1, DPC_WIDTH_OFF, 32'h3);
    acq(32'h87654321);
    tick(4);
    apb(0, DPC_PACK_OFF, 0);
    `CHK("pack 32", 32'h87654321, rd)
    $display("pack test done");
  endtask
  task automatic t_func;
    apb(1, DPC_FUNC_OFF, 32'h00F8001D);
    rso <= 8'h01;
    fp_in <= 8'h02;
    tick(3);
    `CHK("fp0 oe_n", 1'b0, fp_oe_n[0])
    `CHK("fp0 out", 1'b1, fp_out[0])
    `CHK("fp1 oe_n", 1'b1, fp_oe_n[1])
    `CHK("fp1 in", 1'b1, rsi[1])
    `CHK("fp6 oe_n", 1'b1, fp_oe_n[6])
    `CHK("fp7 oe_n", 1'b0, fp_oe_n[7])
    apb(1, DPC_FUNC_OFF, 32'h00200000);
    tick(3);
    `CHK("fp7 serial oe_n", 1'b1, fp_oe_n[7])
    `CHK("fp0 released", 1'b1, fp_oe_n[0])
    $display("function test done");
  endtask
  task automatic t_clk;
    apb(1, DPC_CLK_OFF, 32'h105);
    jlvl <= 1;
    tick(4);
    `CHK("in sel", 1'b1, in_sel)
    `CHK("clk out hi", 1'b1, cko)
    jlvl <= 0;
    tick(4);
    `CHK("clk out lo", 1'b0, cko)
    apb(1, DPC_CLK_OFF, 32'h106);
    osc <= 1;
    tick(4);
    `CHK("clk out side", 1'b1, cko)
    `CHK("out sel", 1'b1, out_sel)
    apb(1, DPC_FUNC_OFF, 32'h00180000);
    tick(4);
    `CHK("fp6 clk in lo", 1'b0, cko)
    fp_in <= 8'h40;
    tick(4);
    `CHK("fp6 clk in hi", 1'b1, cko)
    $display("clock test done");
  endtask
  task automatic t_misc;
    for (int i = 0; i < 4; i++) begin
      apb(1, DPC_DMA_OFF, 32'(i));
      tick(2);
      `CHK("led", exp_led[i], led)
    end
    apb(1, DPC_LVL_OFF, 32'(DPC_LVL_1V8));
    tick(2);
    `CHK("lvl 1v8", DPC_LVL_1V8, lvl)
    apb(1, DPC_LVL_OFF, 32'(DPC_LVL_2V5));
    apb(1, DPC_LVL_OFF, 32'h3);
    tick(2);
    `CHK("lvl kept", DPC_LVL_2V5, lvl)
    apb(0, 8'h40, 0);
    `CHK("unmapped", 1'b1, err)
    $display("misc test done");
  endtask
  task automatic summarize;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    tick(10);
    presetn <= 1;
    t_reset();
    t_ports();
    t_pack();
    t_func();
    t_clk();
    t_misc();
    summarize();
  end
endmodule
`default_nettype wire
